//--- lwx_cfg.svh
// constants for the latch-write, skip and xor decoder
// Function
// - latch-write opcode: top nibble 1010, next nibble 01tx, low byte is file address.
// - table latch is two separately written bytes; one cycle; status untouched.
// - test-skip: zero file register discards next fetched word, runs a nop cycle.
// - xor-literal: working register xor literal back into working register.
// - xor-literal opcode upper byte is 1011 0100; low byte is the literal.
// - xor-file: result to working register when d=0, file register when d=1.
// - xor-file opcode upper byte is 0000 110d; low byte addresses the file.
// - latch-read copies high or low latch byte to file; latch unchanged.
`ifndef LWX_CFG_SVH
`define LWX_CFG_SVH
`define LWX_OP_LATCH_HI 4'ha
`define LWX_LW_SUB 2'h1
`define LWX_LR_SUB 2'h0
`define LWX_OP_SKIP 8'h33
`define LWX_OP_XORL 8'hb4
`define LWX_OP_XORF 7'h06
`define LWX_T_BIT 9
`define LWX_D_BIT 8
`define LWX_LATCH_RST 16'h0000
`define LWX_LATCH_HI_RST 8'h00
`define LWX_LATCH_LO_RST 8'h00
`define LWX_WORKING_REGISTER_RST 8'h00
`endif

//--- lwx_core.sv
// execute stage for latch write/read, test-skip and xor
`timescale 1ns/1ns
`default_nettype none
`include "lwx_cfg.svh"
module lwx_core
  import lwx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [15:0] instr,
  input wire logic [7:0] fileRdData,
  output logic [7:0] fileAddr,
  output logic [7:0] fileWrData,
  output logic fileWrEn,
  output logic [7:0] workReg,
  output logic [15:0] tableLatch,
  output logic discardNext
);
  lwx_dec_if dec();
  lwx_decoder u_dec (.instr(instr), .dec(dec));

  logic [7:0] tableLatchHigh_reg, tableLatchLow_reg, working_register_reg;
  logic [7:0] fileWrData_reg;
  logic fileWrEn_reg, skip_reg;
  wire nopCycle = skip_reg;
  wire go = instrValid && !nopCycle;
  wire doLw = go && dec.op == LWX_LWRITE;
  wire doLr = go && dec.op == LWX_LREAD;
  wire doSkip = go && dec.op == LWX_SKIP && fileRdData == 8'h00;
  wire doXorl = go && dec.op == LWX_XORL;
  wire doXorf = go && dec.op == LWX_XORF;
  wire [7:0] xorFile = working_register_reg ^ fileRdData;
  wire [7:0] latchByte = dec.selBit ? tableLatchHigh_reg : tableLatchLow_reg;
  wire [7:0] working_register_next = doXorl ? (working_register_reg ^ dec.lowByte) :
                         (doXorf && !dec.selBit) ? xorFile : working_register_reg;
  wire fileWr_next = doLr || (doXorf && dec.selBit);
  wire [7:0] fileData_next = doLr ? latchByte : xorFile;

  assign fileAddr = dec.lowByte;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tableLatchHigh_reg <= `LWX_LATCH_HI_RST;
      tableLatchLow_reg <= `LWX_LATCH_LO_RST;
      working_register_reg <= `LWX_WORKING_REGISTER_RST;
      skip_reg <= 1'b0;
      fileWrEn_reg <= 1'b0;
      fileWrData_reg <= 8'h00;
    end
    else
    begin
      if (doLw && dec.selBit)
        tableLatchHigh_reg <= fileRdData;
      if (doLw && !dec.selBit)
        tableLatchLow_reg <= fileRdData;
      working_register_reg <= working_register_next;
      skip_reg <= doSkip;
      fileWrEn_reg <= fileWr_next;
      fileWrData_reg <= fileData_next;
    end
  end

  assign fileWrEn = fileWrEn_reg;
  assign fileWrData = fileWrData_reg;
  assign workReg = working_register_reg;
  assign tableLatch = {tableLatchHigh_reg, tableLatchLow_reg};
  assign discardNext = skip_reg;

  chk_skip_nop: assert property (@(posedge clk) disable iff (!rst_n)
    doSkip |=> discardNext && !fileWrEn) else $error("skip did not discard");
  chk_skip_one: assert property (@(posedge clk) disable iff (!rst_n)
    discardNext |=> !discardNext) else $error("skip longer than one cycle");
  chk_xorl_working_register: assert property (@(posedge clk) disable iff (!rst_n)
    doXorl |=> workReg == ($past(working_register_reg) ^ $past(dec.lowByte))) else $error("xor literal wrong");
  chk_xorl_code: assert property (@(posedge clk) disable iff (!rst_n)
    (dec.op == LWX_XORL) |-> instr[15:8] == 8'hb4) else $error("xor literal decode");
  chk_xorf_dest: assert property (@(posedge clk) disable iff (!rst_n)
    (doXorf && dec.selBit) |=> fileWrEn && fileWrData == $past(xorFile) && workReg == $past(working_register_reg))
    else $error("xor file dest wrong");
  chk_xorf_code: assert property (@(posedge clk) disable iff (!rst_n)
    (dec.op == LWX_XORF) |-> instr[15:9] == 7'h06) else $error("xor file decode");
  chk_lw_byte: assert property (@(posedge clk) disable iff (!rst_n)
    (doLw && !dec.selBit) |=> tableLatch == {$past(tableLatchHigh_reg), $past(fileRdData)})
    else $error("latch low write wrong");
  chk_lw_code: assert property (@(posedge clk) disable iff (!rst_n)
    (dec.op == LWX_LWRITE) |-> instr[15:10] == 6'h29) else $error("latch write decode");
  chk_lw_high: assert property (@(posedge clk) disable iff (!rst_n)
    (doLw && dec.selBit) |=> tableLatch == {$past(fileRdData), $past(tableLatchLow_reg)})
    else $error("latch high write wrong");
  chk_lr_keep: assert property (@(posedge clk) disable iff (!rst_n)
    doLr |=> fileWrEn && fileWrData == $past(latchByte) && $stable(tableLatch))
    else $error("latch read wrong");
endmodule
`default_nettype wire

//--- lwx_dec_if.sv
// decoded instruction carrier
`timescale 1ns/1ns
`default_nettype none
interface lwx_dec_if;
  import lwx_pkg::*;
  lwx_op_t op;
  logic selBit;
  logic [7:0] lowByte;
  modport src (output op, output selBit, output lowByte);
  modport dst (input op, input selBit, input lowByte);
endinterface
`default_nettype wire

//--- lwx_decoder.sv
// opcode decoder
`timescale 1ns/1ns
`default_nettype none
`include "lwx_cfg.svh"
module lwx_decoder
  import lwx_pkg::*;
(
  input wire logic [15:0] instr,
  lwx_dec_if.src dec
);
  wire isLw = (instr[15:12] == `LWX_OP_LATCH_HI) && (instr[11:10] == `LWX_LW_SUB);
  wire isLr = (instr[15:12] == `LWX_OP_LATCH_HI) && (instr[11:10] == `LWX_LR_SUB);
  wire isSkip = instr[15:8] == `LWX_OP_SKIP;
  wire isXorl = instr[15:8] == `LWX_OP_XORL;
  wire isXorf = instr[15:9] == `LWX_OP_XORF;
  assign dec.op = isLw ? LWX_LWRITE : isLr ? LWX_LREAD : isSkip ? LWX_SKIP :
                  isXorl ? LWX_XORL : isXorf ? LWX_XORF : LWX_NONE;
  assign dec.selBit = isXorf ? instr[`LWX_D_BIT] : instr[`LWX_T_BIT];
  assign dec.lowByte = instr[7:0];
endmodule
`default_nettype wire

//--- lwx_pkg.sv
// types for the latch-write, skip and xor decoder
package lwx_pkg;
  typedef enum logic [2:0] {LWX_NONE, LWX_LWRITE, LWX_LREAD, LWX_SKIP, LWX_XORL, LWX_XORF} lwx_op_t;
endpackage

//--- test_latch_write_skip_xor_decode.sv
// self-checking bench for the latch, skip and xor execute stage
`timescale 1ns/1ns
`default_nettype none
module test_latch_write_skip_xor_decode
  import lwx_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [7:0] fileRdData = 8'h00;
  logic [7:0] fileAddr;
  logic [7:0] fileWrData;
  logic fileWrEn;
  logic [7:0] workReg;
  logic [15:0] tableLatch;
  logic discardNext;
  int num_errors = 0;
  int checks = 0;
  always #5 clk = ~clk;
  lwx_core u_lwx_core (.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instr(instr),
    .fileRdData(fileRdData), .fileAddr(fileAddr), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
    .workReg(workReg), .tableLatch(tableLatch), .discardNext(discardNext));
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // present one word, let one edge execute it
  task automatic issue(input logic [15:0] i, input logic [7:0] d);
    instr = i;
    fileRdData = d;
    instrValid = 1'b1;
    #1;
    cmp("fileAddr", {8'h00, i[7:0]}, {8'h00, fileAddr});
    @(posedge clk);
    #1;
  endtask
  task automatic latch_write;
    issue(16'ha410, 8'hb7);
    cmp("tableLatch", 16'h00b7, tableLatch);
    issue(16'ha620, 8'h5a);
    cmp("tableLatch", 16'h5ab7, tableLatch);
    cmp("fileWrEn", 16'h0000, {15'h0000, fileWrEn});
    issue(16'ha730, 8'hc3);
    cmp("tableLatch", 16'hc3b7, tableLatch);
  endtask
  task automatic latch_read;
    issue(16'ha241, 8'h00);
    cmp("fileWrData", 16'h00c3, {8'h00, fileWrData});
    cmp("fileWrEn", 16'h0001, {15'h0000, fileWrEn});
    issue(16'ha042, 8'h00);
    cmp("fileWrData", 16'h00b7, {8'h00, fileWrData});
    cmp("tableLatch", 16'hc3b7, tableLatch);
  endtask
  task automatic xor_literal;
    issue(16'hb40f, 8'h00);
    cmp("workReg", 16'h000f, {8'h00, workReg});
    issue(16'hb4f0, 8'h00);
    issue(16'hb50f, 8'h00);
    cmp("workReg", 16'h00ff, {8'h00, workReg});
  endtask
  task automatic xor_file;
    issue(16'h0c50, 8'haf);
    cmp("workReg", 16'h0050, {8'h00, workReg});
    issue(16'h0d51, 8'h0a);
    cmp("fileWrData", 16'h005a, {8'h00, fileWrData});
    cmp("fileWrEn", 16'h0001, {15'h0000, fileWrEn});
    cmp("workReg", 16'h0050, {8'h00, workReg});
  endtask
  task automatic skip_zero;
    issue(16'h33aa, 8'h00);
    cmp("discardNext", 16'h0001, {15'h0000, discardNext});
    issue(16'hb4ff, 8'h00);
    cmp("workReg", 16'h0050, {8'h00, workReg});
    issue(16'h33ab, 8'h01);
    cmp("discardNext", 16'h0000, {15'h0000, discardNext});
    issue(16'hb4ff, 8'h00);
    cmp("workReg", 16'h00af, {8'h00, workReg});
  endtask
  task automatic conclude;
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cmp("tableLatch", 16'h0000, tableLatch);
    cmp("workReg", 16'h0000, {8'h00, workReg});
    latch_write();
    latch_read();
    xor_literal();
    xor_file();
    skip_zero();
    conclude();
  end
endmodule
`default_nettype wire
